/* bench/tb_three_wire_serial_port.sv */
/*
   self-checking bench for the three-wire serial port.
   assumes the peer model beside it and a 100 MHz clock.
*/
`timescale 1ns/1ns
module tb_three_wire_serial_port;
   import tws_pkg::*;
   // mode, clock select, sent byte, peer byte; cks 0/1 rows use flat peer
   // bytes because the pin synchroniser cannot follow such fast bits
   localparam logic [31:0] ROWS [7] = '{32'hC010A5FF, 32'hD0013C00, 32'hC00A965A,
      32'hD01B81C3, 32'h8014006E, 32'h900500B1, 32'hC01E7E24};
   logic        clk, rst_n, ce, cyc, stb, we, ss_n, tb_sck, p_load, p_rise;
   logic        ack, sck, sck_oe, so, so_oe, flag, si;
   logic [17:0] adr;
   logic [31:0] wdat, r, rdat;
   logic [7:0]  p_tx, p_rx, m, c, d, p;
   int          p_bits, fcnt, f0, n, cyc_cnt, fail_count, n_checks;
   wire         sck_w = sck_oe ? sck : tb_sck;
   // a released data pin shows garbage to the peer, never a stale bit
   wire         so_w = so_oe ? so : ~so;

   tws_top dut_u (.i_clk(clk), .i_reset_n(rst_n), .i_ce(ce), .i_wb_adr(adr),
      .i_wb_dat(wdat), .i_wb_sel(4'hF), .i_wb_we(we), .i_wb_cyc(cyc), .i_wb_stb(stb),
      .o_wb_ack(ack), .o_wb_dat(rdat), .i_sck(sck_w), .o_sck(sck), .o_sck_oe(sck_oe),
      .i_si(si), .o_so(so), .o_so_oe(so_oe), .i_ss_n(ss_n),
      .o_transfer_complete_irq_flag(flag));
   tws_peer_model peer_u (.i_sck(sck_w), .i_so(so_w), .i_rise(p_rise), .i_load(p_load),
      .i_tx(p_tx), .o_si(si), .o_rx(p_rx), .o_bits(p_bits));

   initial
   begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end
   always @(negedge clk)
      if (flag === 1'h1)
         fcnt <= fcnt + 1;
   always @(posedge clk)
   begin
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == 20000)
      begin
         fail_count++;
         $display("MISMATCH timeout expected done seen hang");
         summarize();
      end
   end

   function automatic logic [7:0] ord(input logic [7:0] x, input logic lsb);
      logic [7:0] y;
      for (int i = 0; i < 8; i++)
         y[i] = x[7-i];
      return lsb ? y : x;
   endfunction
   task automatic chk_byte(input string s, input logic [7:0] e, input logic [7:0] g);
      n_checks++;
      if (g !== e)
      begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic chk_bit(input string s, input logic e, input logic g);
      chk_byte(s, {7'h0, e}, {7'h0, g});
   endtask
   task automatic chk_int(input string s, input int e, input int g);
      chk_byte(s, e[7:0], g[7:0]);
   endtask
   // classic single cycle; ack and read data are taken at the same rising edge
   task automatic wb(input logic [15:0] x, input logic w, input logic [7:0] v);
      @(posedge clk);
      adr <= {x, 2'h0};
      we <= w;
      wdat <= {24'h0, v};
      {cyc, stb} <= 2'h3;
      do
      begin
         @(posedge clk);
      end while (ack !== 1'h1);
      r = rdat;
      {cyc, stb, we} <= 3'h0;
   endtask
   task automatic load(input logic [7:0] v, input logic e);
      @(posedge clk);
      p_tx <= v;
      p_rise <= e;
      p_load <= 1'h1;
      @(posedge clk);
      p_load <= 1'h0;
   endtask
   task automatic wait_done(output int k);
      f0 = fcnt;
      k = 0;
      while (fcnt == f0 && k < 3000)
      begin
         @(posedge clk);
         k++;
      end
      @(negedge clk);
      chk_int("flags", 1, fcnt - f0);
   endtask
   task automatic slave_clk(input int k);
      repeat (k)
      begin
         repeat (10) @(posedge clk);
         tb_sck <= ~tb_sck;
      end
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   initial
   begin
      {rst_n, cyc, stb, we, tb_sck, p_load, p_rise} = 7'h0;
      ce = 1'h1;
      ss_n = 1'h1;
      {adr, wdat, p_tx} = '0;
      {fcnt, cyc_cnt, fail_count, n_checks} = '0;
      repeat (20) @(posedge clk);
      rst_n <= 1'h1;
      repeat (3) @(posedge clk);
      wb(TWS_IDX_MODE, 1'h1, 8'h01);
      wb(TWS_IDX_MODE, 1'h0, 8'h00);
      chk_byte("mode", 8'h00, r[7:0]);
      wb(TWS_IDX_CLKSEL, 1'h0, 8'h00);
      chk_byte("clksel", 8'h10, r[7:0]);
      wb(16'hFFB5, 1'h0, 8'h00);
      chk_byte("unmapped", 8'h00, r[7:0]);
      chk_bit("so_oe", 1'h0, so_oe);
      $display("test reset done");
      wb(TWS_IDX_MODE, 1'h1, 8'hC0);
      wb(TWS_IDX_CLKSEL, 1'h1, 8'h16);
      wb(TWS_IDX_TXBUF, 1'h1, 8'h55);
      repeat (100) @(posedge clk);
      // a freeze longer than the whole transfer must leave it still busy
      ce <= 1'h0;
      repeat (1100) @(posedge clk);
      ce <= 1'h1;
      wb(TWS_IDX_MODE, 1'h0, 8'h00);
      chk_byte("busy", 8'hC1, r[7:0]);
      f0 = fcnt;
      wb(TWS_IDX_MODE, 1'h1, 8'h40);
      wb(TWS_IDX_MODE, 1'h0, 8'h00);
      chk_byte("stopped", 8'h40, r[7:0]);
      @(negedge clk);
      chk_bit("sck_oe", 1'h0, sck_oe);
      chk_bit("so_oe off", 1'h0, so_oe);
      repeat (1100) @(posedge clk);
      chk_int("no flag", 0, fcnt - f0);
      $display("test stop done");
      for (int i = 0; i < 7; i++)
      begin
         {m, c, d, p} = ROWS[i];
         wb(TWS_IDX_MODE, 1'h1, m);
         wb(TWS_IDX_CLKSEL, 1'h1, c);
         load(p, c[4] == c[3]);
         wb(m[6] ? TWS_IDX_TXBUF : TWS_IDX_SHIFT, m[6], d);
         wait_done(n);
         chk_bit("clocks", 1'h1, n >= (16 << c[2:0]) - 1 && n <= (16 << c[2:0]) + 2);
         chk_int("bits", 8, p_bits);
         chk_byte("peer rx", m[6] ? ord(d, m[4]) : 8'h00, p_rx);
         chk_bit("so", m[6] & (m[4] ? d[7] : d[0]), so);
         chk_bit("sck idle", ~c[4], sck);
         chk_bit("sck_oe", 1'h1, sck_oe);
         chk_bit("so_oe", 1'h1, so_oe);
         wb(TWS_IDX_MODE, 1'h0, 8'h00);
         chk_byte("done", m, r[7:0]);
         load(p, c[4] == c[3]);
         wb(TWS_IDX_SHIFT, 1'h0, 8'h00);
         chk_byte("shift", ord(p, m[4]), r[7:0]);
         wait_done(n);
         $display("test row %0d done", i);
      end
      wb(TWS_IDX_MODE, 1'h1, 8'hE0);
      wb(TWS_IDX_CLKSEL, 1'h1, 8'h17);
      load(8'h69, 1'h0);
      wb(TWS_IDX_TXBUF, 1'h1, 8'hC3);
      repeat (20) @(posedge clk);
      wb(TWS_IDX_MODE, 1'h0, 8'h00);
      chk_byte("pending", 8'hE0, r[7:0]);
      ss_n <= 1'h0;
      repeat (20) @(posedge clk);
      wb(TWS_IDX_MODE, 1'h0, 8'h00);
      chk_byte("started", 8'hE1, r[7:0]);
      slave_clk(16);
      wait_done(n);
      chk_byte("peer rx", 8'hC3, p_rx);
      load(8'h69, 1'h0);
      wb(TWS_IDX_SHIFT, 1'h0, 8'h00);
      chk_byte("shift", 8'h69, r[7:0]);
      f0 = fcnt;
      slave_clk(6);
      ss_n <= 1'h1;
      repeat (20) @(posedge clk);
      wb(TWS_IDX_MODE, 1'h0, 8'h00);
      chk_byte("aborted", 8'hE0, r[7:0]);
      chk_int("no flag", 0, fcnt - f0);
      load(8'h3A, 1'h0);
      wb(TWS_IDX_SHIFT, 1'h0, 8'h00);
      repeat (20) @(posedge clk);
      ss_n <= 1'h0;
      repeat (20) @(posedge clk);
      wb(TWS_IDX_MODE, 1'h0, 8'h00);
      chk_byte("rx started", 8'hE1, r[7:0]);
      slave_clk(16);
      wait_done(n);
      wb(TWS_IDX_SHIFT, 1'h0, 8'h00);
      chk_byte("rx shift", 8'h3A, r[7:0]);
      $display("test slave done");
      // reset in mid-run, with a reception still under way
      rst_n <= 1'h0;
      repeat (3) @(posedge clk);
      chk_bit("rst sck_oe", 1'h0, sck_oe);
      chk_bit("rst so_oe", 1'h0, so_oe);
      chk_bit("rst sck", 1'h0, sck);
      chk_bit("rst flag", 1'h0, flag);
      rst_n <= 1'h1;
      repeat (3) @(posedge clk);
      wb(TWS_IDX_MODE, 1'h0, 8'h00);
      chk_byte("rst mode", 8'h00, r[7:0]);
      wb(TWS_IDX_CLKSEL, 1'h0, 8'h00);
      chk_byte("rst clksel", 8'h10, r[7:0]);
      $display("test mid reset done");
      summarize();
   end
endmodule

/* bench/tws_peer_model.sv */
/*
   far-side clocked serial peripheral: shifts a byte out on si, collects so.
   assumes the serial clock wire is already resolved from both drivers.
*/
`timescale 1ns/1ns
module tws_peer_model (
   input  wire logic       i_sck,
   input  wire logic       i_so,
   input  wire logic       i_rise,
   input  wire logic       i_load,
   input  wire logic [7:0] i_tx,
   output logic            o_si,
   output logic      [7:0] o_rx,
   output int              o_bits
);
   logic [7:0] tx_q;
   initial o_si = 1'h0;
   // data moves on the edge opposite the sampling edge, so it is
   // never caught by the synchroniser in the middle of a change
   always @(posedge i_load or posedge i_sck or negedge i_sck)
   begin
      if (i_load)
      begin
         tx_q   = i_tx;
         o_rx   = 8'h00;
         o_bits = 0;
         o_si   = i_tx[7];
      end
      else if (i_sck == i_rise)
      begin
         if (o_bits < 8)
         begin
            o_rx   = {o_rx[6:0], i_so};
            tx_q   = {tx_q[6:0], 1'h0};
            o_bits = o_bits + 1;
         end
      end
      else
         o_si = (o_bits < 8) ? tx_q[7] : ~o_si;
   end
endmodule

/* core/tws_clk_if.sv */
/*
   link between the transfer engine and the serial clock prescaler.
   assumes both ends run on the system clock.
*/
`timescale 1ns/1ns
interface tws_clk_if;
   logic       run;
   logic [2:0] sel;
   logic       tick;

   modport gen  (input run, input sel, output tick);
   modport user (output run, output sel, input tick);
endinterface

/* core/tws_clkdiv.sv */
/*
   serial clock prescaler: one tick per half serial clock period.
   assumes run is low whenever no master transfer is under way.
*/
`timescale 1ns/1ns
module tws_clkdiv (
   input  wire logic i_clk,
   input  wire logic i_rst_n,
   input  wire logic i_ce,
   tws_clk_if.gen    clk_if
);
   import tws_pkg::*;

   logic [6:0] cnt_q;
   logic [6:0] mask;

   // half period is 2^sel system clocks, so the serial clock is divided by 2^(sel+1)
   assign mask        = 7'((8'h01 << clk_if.sel) - 8'h01);
   assign clk_if.tick = clk_if.run & ((cnt_q & mask) == mask);

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         cnt_q <= 7'h00;
      else if (i_ce)
      begin
         if (!clk_if.run)
            cnt_q <= 7'h00;
         else
            cnt_q <= 7'(cnt_q + 7'h01);
      end
   end
endmodule

/* core/tws_pkg.sv */
/*
   constants, register map and state type of the three-wire serial port.
   assumes a 32-bit classic wishbone slave and a 100 MHz system clock.
*/
package tws_pkg;

   localparam int unsigned TWS_ADR_W      = 18;
   localparam int unsigned TWS_DAT_W      = 32;

   // register indices; byte address is four times the index
   localparam logic [15:0] TWS_IDX_MODE   = 16'hFFB0;
   localparam logic [15:0] TWS_IDX_CLKSEL = 16'hFFB1;
   localparam logic [15:0] TWS_IDX_TXBUF  = 16'hFFB2;
   localparam logic [15:0] TWS_IDX_SHIFT  = 16'hFFB3;

   // mode/control field positions
   localparam int unsigned TWS_EN_BIT     = 7;
   localparam int unsigned TWS_TRMD_BIT   = 6;
   localparam int unsigned TWS_SSE_BIT    = 5;
   localparam int unsigned TWS_DIR_BIT    = 4;
   localparam int unsigned TWS_BUSY_BIT   = 0;

   // clock/phase select field positions
   localparam int unsigned TWS_CKP_BIT    = 4;
   localparam int unsigned TWS_DAP_BIT    = 3;
   localparam int unsigned TWS_CKS_LSB    = 0;

   // reset values
   localparam logic [7:0]  TWS_MODE_RST   = 8'h00;
   localparam logic [7:0]  TWS_CLKSEL_RST = 8'h10;
   localparam logic        TWS_SCK_RST    = 1'h0;

   localparam logic [2:0]  TWS_CKS_EXT    = 3'h7;
   localparam logic [4:0]  TWS_LAST_EDGE  = 5'hF;

   typedef enum logic {TWS_IDLE, TWS_RUN} tws_state_type;

endpackage

/* core/tws_sync.sv */
/*
   two flip-flop synchroniser for pin inputs.
   assumes inputs are asynchronous to i_clk.
*/
`timescale 1ns/1ns
module tws_sync #(
   parameter int           W       = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input  wire logic         i_clk,
   input  wire logic         i_rst_n,
   input  wire logic         i_ce,
   input  wire logic [W-1:0] i_d,
   output logic      [W-1:0] o_q
);
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         meta_q <= RST_VAL;
         sync_q <= RST_VAL;
      end
      else if (i_ce)
      begin
         meta_q <= i_d;
         sync_q <= meta_q;
      end
   end

   assign o_q = sync_q;
endmodule

/* core/tws_top.sv */
/*
   three-wire serial port: wishbone register file, transfer engine,
   slave-select gating and pin control.
   assumes a classic wishbone master on i_clk and pins asynchronous to it.
*/
// Summary of operation
// - one 8-bit character over clock, out, in
// - transmit/receive mode shifts both directions together
// - first-bit select: 0 MSB first, 1 LSB
// - buffer write starts transfer when mode bit set
// - buffer value loads shift register, drives output
// - shift register read starts reception, either mode
// - reception samples input into shift register
// - slave select high holds buffer-write start pending
// - pending start begins when select falls low
// - select rising mid-transfer aborts the transfer
// - reception follows the same select gating
// - enable low stops logic, releases pins
// - receive-only mode holds serial output low
// - busy flag read-only, high during transfer
// - clearing enable clears busy flag
// - clock select: divide by 2..128 or external
// - polarity and phase give four types; reset type 3
// - data registers have no reset value
// - completion pulses flag and clears busy
// - output holds last bit after completion
`timescale 1ns/1ns
module tws_top (
   input  wire logic                           i_clk,
   input  wire logic                           i_reset_n,
   input  wire logic                           i_ce,
   input  wire logic [tws_pkg::TWS_ADR_W-1:0]  i_wb_adr,
   input  wire logic [tws_pkg::TWS_DAT_W-1:0]  i_wb_dat,
   input  wire logic [3:0]                     i_wb_sel,
   input  wire logic                           i_wb_we,
   input  wire logic                           i_wb_cyc,
   input  wire logic                           i_wb_stb,
   output logic                                o_wb_ack,
   output logic      [tws_pkg::TWS_DAT_W-1:0]  o_wb_dat,
   input  wire logic                           i_sck,
   output logic                                o_sck,
   output logic                                o_sck_oe,
   input  wire logic                           i_si,
   output logic                                o_so,
   output logic                                o_so_oe,
   input  wire logic                           i_ss_n,
   output logic                                o_transfer_complete_irq_flag
);
   import tws_pkg::*;

   logic          [1:0]  rst_sync_q;
   logic                 rst_n;
   logic          [2:0]  pins_s;
   logic                 sck_s;
   logic                 si_s;
   logic                 ss_s;
   logic                 sck_prev_q;

   logic                 en_q;
   logic                 trmd_q;
   logic                 sse_q;
   logic                 dir_q;
   logic                 ckp_q;
   logic                 dap_q;
   logic          [2:0]  cks_q;
   logic          [7:0]  txbuf_q;
   logic          [7:0]  sr_q;

   logic                 ack_q;
   logic          [31:0] rdat_q;
   logic                 wb_req;
   logic          [15:0] idx;
   logic                 wr_lo;
   logic                 rd;
   logic                 hit_mode;
   logic                 hit_clk;
   logic                 hit_tx;
   logic                 hit_sr;
   logic          [7:0]  mode_rd;
   logic          [7:0]  clk_rd;

   tws_state_type        state_q;
   logic          [4:0]  hc_q;
   logic                 pend_q;
   logic                 busy;
   logic                 slave_mode;
   logic                 gated;
   logic                 ss_block;
   logic                 tx_start_req;
   logic                 rx_start_req;
   logic                 go;
   logic                 abort;
   logic                 ev;
   logic                 lead;
   logic                 sample;
   logic                 drive;
   logic                 done;
   logic                 idle_lvl;
   logic          [7:0]  tx_load;
   logic                 out_bit;
   logic                 first_bit;

   logic                 sck_q;
   logic                 sck_oe_q;
   logic                 so_q;
   logic                 so_oe_q;
   logic                 irq_q;

   tws_clk_if            clk_if ();

   // reset release is synchronised; assertion stays asynchronous
   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
         rst_sync_q <= 2'h0;
      else if (i_ce)
         rst_sync_q <= {rst_sync_q[0], 1'h1};
   end
   assign rst_n = rst_sync_q[1];

   // select resets high so a slave sits deselected; clock low to match the edge detector
   tws_sync #(
      .W       (3),
      .RST_VAL (3'h1)
   ) u_sync (
      .i_clk   (i_clk),
      .i_rst_n (rst_n),
      .i_ce    (i_ce),
      .i_d     ({i_sck, i_si, i_ss_n}),
      .o_q     (pins_s)
   );
   assign sck_s = pins_s[2];
   assign si_s  = pins_s[1];
   assign ss_s  = pins_s[0];

   tws_clkdiv u_clkdiv (
      .i_clk   (i_clk),
      .i_rst_n (rst_n),
      .i_ce    (i_ce),
      .clk_if  (clk_if.gen)
   );

   // bus decode; one request per ack, ack drops the cycle after
   assign wb_req   = i_wb_cyc & i_wb_stb & ~ack_q;
   assign idx      = i_wb_adr[TWS_ADR_W-1:2];
   assign wr_lo    = wb_req & i_wb_we & i_wb_sel[0];
   assign rd       = wb_req & ~i_wb_we;
   assign hit_mode = (idx == TWS_IDX_MODE);
   assign hit_clk  = (idx == TWS_IDX_CLKSEL);
   assign hit_tx   = (idx == TWS_IDX_TXBUF);
   assign hit_sr   = (idx == TWS_IDX_SHIFT);

   assign busy    = (state_q == TWS_RUN);
   assign mode_rd = {en_q, trmd_q, sse_q, dir_q, 3'h0, busy};
   assign clk_rd  = {3'h0, ckp_q, dap_q, cks_q};

   always_ff @(posedge i_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ack_q  <= 1'h0;
         rdat_q <= 32'h00000000;
      end
      else if (i_ce)
      begin
         ack_q <= wb_req;
         if (rd)
         begin
            // unmapped indices read as zero and are still acknowledged
            if (hit_mode)
               rdat_q <= {24'h000000, mode_rd};
            else if (hit_clk)
               rdat_q <= {24'h000000, clk_rd};
            else if (hit_tx)
               rdat_q <= {24'h000000, txbuf_q};
            else if (hit_sr)
               rdat_q <= {24'h000000, sr_q};
            else
               rdat_q <= 32'h00000000;
         end
      end
   end

   // mode/control register; busy bit is not writable
   always_ff @(posedge i_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         en_q   <= TWS_MODE_RST[TWS_EN_BIT];
         trmd_q <= TWS_MODE_RST[TWS_TRMD_BIT];
         sse_q  <= TWS_MODE_RST[TWS_SSE_BIT];
         dir_q  <= TWS_MODE_RST[TWS_DIR_BIT];
      end
      else if (i_ce && wr_lo && hit_mode)
      begin
         en_q   <= i_wb_dat[TWS_EN_BIT];
         trmd_q <= i_wb_dat[TWS_TRMD_BIT];
         sse_q  <= i_wb_dat[TWS_SSE_BIT];
         dir_q  <= i_wb_dat[TWS_DIR_BIT];
      end
   end

   // clock/phase select; reset value gives phase type 3
   always_ff @(posedge i_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ckp_q <= TWS_CLKSEL_RST[TWS_CKP_BIT];
         dap_q <= TWS_CLKSEL_RST[TWS_DAP_BIT];
         cks_q <= TWS_CLKSEL_RST[TWS_CKS_LSB+:3];
      end
      else if (i_ce && wr_lo && hit_clk)
      begin
         ckp_q <= i_wb_dat[TWS_CKP_BIT];
         dap_q <= i_wb_dat[TWS_DAP_BIT];
         cks_q <= i_wb_dat[TWS_CKS_LSB+:3];
      end
   end

   // start, gating and abort
   assign slave_mode   = (cks_q == TWS_CKS_EXT);
   assign gated        = en_q & sse_q & slave_mode;
   assign ss_block     = gated & ss_s;
   assign tx_start_req = wr_lo & hit_tx & en_q & trmd_q;
   assign rx_start_req = rd & hit_sr & en_q;
   assign go           = en_q & (state_q == TWS_IDLE)
                         & (tx_start_req | rx_start_req | pend_q) & ~ss_block;
   assign abort        = busy & ss_block;

   always_ff @(posedge i_clk or negedge rst_n)
   begin
      if (!rst_n)
         pend_q <= 1'h0;
      else if (i_ce)
      begin
         if (!en_q || go)
            pend_q <= 1'h0;
         else if (tx_start_req || rx_start_req)
            pend_q <= 1'h1;
      end
   end

   // edge events: prescaler ticks as master, synchronised pin edges as slave
   assign idle_lvl        = ~ckp_q;
   assign clk_if.run      = busy & ~slave_mode;
   assign clk_if.sel      = cks_q;
   assign ev              = busy & (slave_mode ? (sck_s ^ sck_prev_q) : clk_if.tick);
   assign lead            = ~hc_q[0];
   assign sample          = ev & (lead == dap_q);
   assign drive           = ev & (lead != dap_q) & (hc_q != TWS_LAST_EDGE);
   assign done            = ev & (hc_q == TWS_LAST_EDGE);
   assign tx_load         = (wr_lo && hit_tx) ? i_wb_dat[7:0] : txbuf_q;
   assign out_bit         = dir_q ? sr_q[0] : sr_q[7];
   assign first_bit       = dir_q ? tx_load[0] : tx_load[7];

   always_ff @(posedge i_clk or negedge rst_n)
   begin
      if (!rst_n)
         sck_prev_q <= TWS_SCK_RST;
      else if (i_ce)
         sck_prev_q <= sck_s;
   end

   always_ff @(posedge i_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q <= TWS_IDLE;
         hc_q    <= 5'h00;
      end
      else if (i_ce)
      begin
         case (state_q)
            TWS_IDLE:
            begin
               hc_q <= 5'h00;
               if (go)
                  state_q <= TWS_RUN;
            end
            TWS_RUN:
            begin
               if (!en_q || abort || done)
                  state_q <= TWS_IDLE;
               else if (ev)
                  hc_q <= 5'(hc_q + 5'h01);
            end
            default:
               state_q <= TWS_IDLE;
         endcase
      end
   end

   // data registers carry no reset
   always_ff @(posedge i_clk)
   begin
      if (i_ce && wr_lo && hit_tx)
         txbuf_q <= i_wb_dat[7:0];
   end

   always_ff @(posedge i_clk)
   begin
      if (i_ce)
      begin
         if (go && trmd_q)
            sr_q <= tx_load;
         else if (sample && !abort)
         begin
            if (dir_q)
               sr_q <= {si_s, sr_q[7:1]};
            else
               sr_q <= {sr_q[6:0], si_s};
         end
      end
   end

   // pins; data out holds its last bit between transfers
   always_ff @(posedge i_clk or negedge rst_n)
   begin
      if (!rst_n)
         so_q <= 1'h0;
      else if (i_ce)
      begin
         if (!trmd_q)
            so_q <= 1'h0;
         else if (go && dap_q)
            so_q <= first_bit;
         else if (drive && !abort)
            so_q <= out_bit;
      end
   end

   always_ff @(posedge i_clk or negedge rst_n)
   begin
      if (!rst_n)
         sck_q <= TWS_SCK_RST;
      else if (i_ce)
      begin
         if (!busy || slave_mode)
            sck_q <= idle_lvl;
         else if (clk_if.tick)
            sck_q <= ~sck_q;
      end
   end

   always_ff @(posedge i_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sck_oe_q <= 1'h0;
         so_oe_q  <= 1'h0;
         irq_q    <= 1'h0;
      end
      else if (i_ce)
      begin
         sck_oe_q <= en_q & ~slave_mode;
         so_oe_q  <= en_q;
         irq_q    <= done & en_q & ~abort;
      end
   end

   assign o_wb_ack                     = ack_q;
   assign o_wb_dat                     = rdat_q;
   assign o_sck                        = sck_q;
   assign o_sck_oe                     = sck_oe_q;
   assign o_so                         = so_q;
   assign o_so_oe                      = so_oe_q;
   assign o_transfer_complete_irq_flag = irq_q;

   // checks; frozen cycles are not judged
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!rst_n || !i_ce);

   AST_TX_START: assert property (
      (tx_start_req && !busy && !ss_block) |=> busy)
      else $error("transmit buffer write did not start a transfer");

   AST_RX_START: assert property (
      (rx_start_req && !busy && !ss_block) |=> busy)
      else $error("shift register read did not start a reception");

   AST_SS_PENDING: assert property (
      (!busy && ss_block && (tx_start_req || rx_start_req)) |=> (!busy && pend_q))
      else $error("start not held pending while select is high");

   AST_SS_RELEASE: assert property (
      (pend_q && !busy && en_q && !ss_block) |=> busy)
      else $error("pending transfer did not begin on select low");

   AST_SS_ABORT: assert property (
      (busy && ss_block) |=> (!busy && !o_transfer_complete_irq_flag))
      else $error("transfer not aborted by select high");

   AST_DISABLE: assert property (
      (!en_q) |=> (!busy && !o_sck_oe && !o_so_oe))
      else $error("disabled port still busy or driving");

   AST_RX_ONLY_LOW: assert property (
      (!trmd_q) |=> !o_so)
      else $error("serial output not low in receive-only mode");

   AST_FAST_MASTER: assert property (
      (go && cks_q == 3'h0 && !gated) |=> ##15 (done || !en_q)
         ##1 (!busy && (o_transfer_complete_irq_flag || !$past(en_q))))
      else $error("fastest master transfer not sixteen edges long");

   AST_DONE_FLAG: assert property (
      (done && en_q && !abort) |=> (o_transfer_complete_irq_flag && !busy))
      else $error("completion did not pulse flag and clear busy");

   AST_HOLD_LAST: assert property (
      (!busy && !go && trmd_q && $past(trmd_q)) |=> $stable(o_so))
      else $error("serial output moved between transfers");

   AST_BIT_ORDER: assert property (
      (drive && trmd_q && !abort) |=> (o_so == $past(dir_q ? sr_q[0] : sr_q[7])))
      else $error("output bit not taken from the selected end");

   AST_SAMPLE_IN: assert property (
      (sample && !abort && !dir_q) |=> (sr_q[0] == $past(si_s)))
      else $error("sampled input not shifted into the register");

   AST_SCK_IDLE: assert property (
      (!busy && !slave_mode && en_q) |=> (o_sck == $past(idle_lvl)))
      else $error("master serial clock not at its idle level");

   COV_TX_DONE: cover property (tx_start_req ##[1:300] o_transfer_complete_irq_flag);
   COV_RX_DONE: cover property (rx_start_req && !trmd_q ##[1:300] o_transfer_complete_irq_flag);
   COV_ABORT:   cover property (busy && ss_block);
   COV_PENDING: cover property (pend_q && !ss_block && !busy);

endmodule
